// ---- verilog/msq_unit.v ----
// microsequencer and memory/device address unit
`timescale 1ns/1ps
`default_nettype none
`include "msq_defs.vh"
// Contract
// R1 - adder takes B, literal/counter, alt pc or address pair; feeds shifter; loads B on command
// R2 - shifter shifts adder word left/right, end-off or end-around, by shift count
// R3 - shifter output loads A, B, write buffer, alt pc, address low, bases, shift count
// R4 - 14-bit micro pc loads from type II word or incrementer
// R5 - micro pc feeds incrementer and alt pc input
// R6 - alt pc holds jump target minus one, return target minus two
// R7 - alt pc loads from micro pc, shifter low 14 bits or type II word
// R8 - incrementer adds 0, 1 or 2 to micro pc or alt pc
// R9 - phase 1 picks load, source, increment from condition and nano successor fields
// R10 - type II microinstruction forces the step successor
// R11 - 8-bit address low concatenates with selected base for the address
// R12 - address low loads from shifter low byte or literal; pair routes to adder
// R13 - each base register is eight bits wide
// R14 - base registers load from shifter high byte
// R15 - base selection sticks until a command picks the other base
// R16 - rw1 picks base one, rw2 base two, none leaves selection unchanged
// R17 - selected base goes to port select unit as device port address
// R18 - 8-bit loop counter loads literal or shifter low byte; right-justified to adder
// R19 - counter overflow sets flag; test or counter load clears it
// R20 - 8-bit literal loads from type II word; left-justified to adder
// R21 - input gates pick literal or shifter low byte, never both
// R22 - 40-bit control register captures nanocontrols not used in phase 1
// R23 - overflow flag: clear wins over set
// R24 - destinations load only when phase 3 completes, not while extended
// R25 - 16-bit address is selected base high byte, address low low byte
module msq_unit (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // phase timing
  input  wire        phase1,
  input  wire        phase3_done,
  input  wire        phase3_ext,
  // microinstruction from firmware store
  input  wire        type2,
  input  wire        type2_pc,
  input  wire        type2_alt,
  input  wire        type2_lit,
  input  wire [13:0] type2_addr,
  input  wire [7:0]  type2_literal,
  input  wire        op_a,
  // nanoinstruction
  input  wire [15:0] nano_succ,
  input  wire        cond_true,
  input  wire [39:0] nano_ctl,
  // data path controls
  input  wire [2:0]  add_src,
  input  wire [1:0]  add_fn,
  input  wire        add_to_b,
  input  wire        shf_left,
  input  wire        shf_around,
  input  wire [8:0]  shf_dest,
  input  wire        in_sel,
  input  wire        ctr_inc,
  input  wire        test_ovf,
  input  wire [1:0]  mem_cmd,
  // data from memory, ports and scratch registers
  input  wire [15:0] b_in,
  input  wire        b_in_load,
  // outputs
  output reg  [13:0] micro_addr_r,
  output reg  [13:0] micro_pc_r,
  output reg  [13:0] alt_micro_pc_r,
  output reg  [15:0] s_addr_r,
  output reg  [7:0]  device_port_r,
  output reg         base_two_sel_r,
  output reg  [15:0] write_buffer_reg_r,
  output reg  [15:0] a_load_r,
  output reg         a_load_en_r,
  output reg  [15:0] adder_out_r,
  output reg         counter_overflow_flag_r,
  output reg  [39:0] nano_ctl_r
);
  // =====================================================
  // local state
  reg  [15:0] b_reg_r;
  reg  [7:0]  literal_reg_r;
  reg  [7:0]  loop_counter_r;
  reg  [7:0]  mem_addr_low_r;
  reg  [7:0]  base_sel_one_r;
  reg  [7:0]  base_sel_two_r;
  reg  [3:0]  shift_count_reg_r;
  reg         base_two_nxt;
  reg  [15:0] adder_nxt;
  reg  [15:0] opnd;
  reg  [7:0]  succ;
  reg  [7:0]  in_gate;
  reg  [13:0] micro_pc_nxt;
  reg  [13:0] micro_addr_nxt;
  reg  [13:0] alt_nxt;
  reg  [7:0]  literal_nxt;
  reg  [15:0] b_nxt;
  reg  [7:0]  ctr_nxt;
  reg         ovf_nxt;
  wire [7:0]  base_pick;
  wire [15:0] shifter_matrix;
  wire [13:0] inc_sum;
  wire        dest_ok = phase3_done & ~phase3_ext; // R24
  wire [8:0]  dst;
  wire [8:0]  ctr_sum = {1'b0, loop_counter_r} + 9'h001;

  // =====================================================
  // adder
  always @* begin
    case (add_src)
      `MSQ_SRC_B:    opnd = b_reg_r;
      `MSQ_SRC_LIT:  opnd = {literal_reg_r, 8'h00}; // R20
      `MSQ_SRC_CTR:  opnd = {8'h00, loop_counter_r}; // R18
      `MSQ_SRC_ALT:  opnd = {2'h0, alt_micro_pc_r};
      `MSQ_SRC_ADDR: opnd = {base_two_sel_r ? base_sel_two_r : base_sel_one_r,
                             mem_addr_low_r}; // R12
      default:       opnd = 16'h0000;
    endcase
    case (add_fn)
      `MSQ_FN_ADD: adder_nxt = opnd + b_reg_r; // R1
      `MSQ_FN_AND: adder_nxt = opnd & b_reg_r;
      `MSQ_FN_OR:  adder_nxt = opnd | b_reg_r;
      default:     adder_nxt = opnd ^ b_reg_r;
    endcase
  end

  // shifter always fed from the adder
  msq_shifter u_shf (
    .din      (adder_nxt), // R1
    .amount   (shift_count_reg_r),
    .dir_left (shf_left),
    .around   (shf_around),
    .dout     (shifter_matrix)
  );

  // =====================================================
  // micro address controls
  always @* begin
    if (type2) begin
      succ = `MSQ_SUC_STEP; // R10
    end else if (cond_true) begin
      succ = nano_succ[`MSQ_N_TRUE_LO +: 8]; // R9
    end else begin
      succ = nano_succ[`MSQ_N_FALSE_LO +: 8]; // R9
    end
  end

  msq_incrementer u_inc (
    .pc      (micro_pc_r), // R5
    .alt     (alt_micro_pc_r),
    .use_alt (succ[2]), // R8
    .inc     (succ[1:0] == 2'h3 ? 2'h2 : succ[1:0]), // R8
    .sum     (inc_sum)
  );

  // =====================================================
  // input selection gates
  always @* begin
    if (in_sel == `MSQ_IN_SHF) in_gate = shifter_matrix[7:0]; // R21
    else in_gate = literal_reg_r; // R21
  end

  // sticky base selection
  always @* begin
    if (mem_cmd == `MSQ_CMD_RW1) base_two_nxt = 1'b0; // R16
    else if (mem_cmd == `MSQ_CMD_RW2) base_two_nxt = 1'b1; // R16
    else base_two_nxt = base_two_sel_r; // R15
  end

  // =====================================================
  // destination load enables; nothing loads until phase 3 completes
  genvar g;
  generate
    for (g = 0; g < `MSQ_DSTW; g = g + 1) begin : g_dst
      assign dst[g] = dest_ok & shf_dest[g]; // R24
    end
  endgenerate

  // =====================================================
  // adder result register
  always @(posedge clk) begin
    if (reset) begin
      adder_out_r <= 16'h0000;
    end else begin
      adder_out_r <= adder_nxt; // R1
    end
  end

  // =====================================================
  // micro pc next value; held during op_a unless a type II word loads it
  always @* begin
    if (phase1 && type2 && type2_pc) begin
      micro_pc_nxt = type2_addr; // R4
    end else if (phase1 && !op_a) begin
      micro_pc_nxt = inc_sum; // R4
    end else begin
      micro_pc_nxt = micro_pc_r;
    end
  end

  // micro memory address follows the incrementer in phase 1
  always @* begin
    if (phase1) begin
      micro_addr_nxt = inc_sum; // R8
    end else begin
      micro_addr_nxt = micro_addr_r;
    end
  end

  // alt pc: type II word or micro pc in phase 1, shifter otherwise
  always @* begin
    if (phase1 && type2 && type2_alt) begin
      alt_nxt = type2_addr; // R7
    end else if (phase1 && succ[3]) begin
      alt_nxt = micro_pc_r; // R7 R6
    end else if (dst[`MSQ_D_ALT] && !phase1) begin
      alt_nxt = shifter_matrix[13:0]; // R7
    end else begin
      alt_nxt = alt_micro_pc_r;
    end
  end

  // literal from a type II word
  always @* begin
    if (phase1 && type2 && type2_lit) begin
      literal_nxt = type2_literal; // R20
    end else begin
      literal_nxt = literal_reg_r;
    end
  end

  // sequencing registers
  always @(posedge clk) begin
    if (reset) begin
      micro_pc_r <= 14'h0000;
      micro_addr_r <= 14'h0000;
      alt_micro_pc_r <= 14'h0000;
      literal_reg_r <= 8'h00;
    end else begin
      micro_pc_r <= micro_pc_nxt; // R4
      micro_addr_r <= micro_addr_nxt; // R8
      alt_micro_pc_r <= alt_nxt; // R7
      literal_reg_r <= literal_nxt; // R20
    end
  end

  // =====================================================
  // control register takes the nanocontrols outside phase 1
  always @(posedge clk) begin
    if (reset) begin
      nano_ctl_r <= 40'h0000000000;
    end else if (!phase1) begin
      nano_ctl_r <= nano_ctl; // R22
    end
  end

  // =====================================================
  // b register: shifter, adder on command, or memory and ports
  always @* begin
    if (dst[`MSQ_D_B]) begin
      b_nxt = shifter_matrix; // R3
    end else if (dest_ok && add_to_b) begin
      b_nxt = adder_nxt; // R1
    end else if (b_in_load) begin
      b_nxt = b_in;
    end else begin
      b_nxt = b_reg_r;
    end
  end

  // data destinations of the shifter matrix
  always @(posedge clk) begin
    if (reset) begin
      b_reg_r <= 16'h0000;
      a_load_r <= 16'h0000;
      a_load_en_r <= 1'b0;
      write_buffer_reg_r <= 16'h0000;
      shift_count_reg_r <= 4'h0;
    end else begin
      b_reg_r <= b_nxt; // R1
      a_load_en_r <= dst[`MSQ_D_A]; // R3
      if (dst[`MSQ_D_A]) a_load_r <= shifter_matrix; // R3
      if (dst[`MSQ_D_WBUF]) write_buffer_reg_r <= shifter_matrix; // R3
      if (dst[`MSQ_D_SHC]) shift_count_reg_r <= shifter_matrix[3:0]; // R3
    end
  end

  // =====================================================
  // address low and base registers
  always @(posedge clk) begin
    if (reset) begin
      mem_addr_low_r <= 8'h00;
      base_sel_one_r <= 8'h00;
      base_sel_two_r <= 8'h00;
    end else begin
      if (dst[`MSQ_D_MAL]) mem_addr_low_r <= in_gate; // R12 R11
      if (dst[`MSQ_D_BS1]) base_sel_one_r <= shifter_matrix[15:8]; // R14 R13
      if (dst[`MSQ_D_BS2]) base_sel_two_r <= shifter_matrix[15:8]; // R14
    end
  end

  // =====================================================
  // loop counter: load from the input gates or count up
  always @* begin
    if (dst[`MSQ_D_CTR]) begin
      ctr_nxt = in_gate; // R18
    end else if (ctr_inc) begin
      ctr_nxt = ctr_sum[7:0];
    end else begin
      ctr_nxt = loop_counter_r;
    end
  end

  // overflow flag: a clear by test or counter load beats a set
  always @* begin
    if (test_ovf || dst[`MSQ_D_CTR]) begin
      ovf_nxt = 1'b0; // R19 R23
    end else if (ctr_inc && ctr_sum[8]) begin
      ovf_nxt = 1'b1; // R19
    end else begin
      ovf_nxt = counter_overflow_flag_r;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      loop_counter_r <= 8'h00;
      counter_overflow_flag_r <= 1'b0;
    end else begin
      loop_counter_r <= ctr_nxt; // R18
      counter_overflow_flag_r <= ovf_nxt; // R19
    end
  end

  // =====================================================
  // output selection gates use this edge's command
  assign base_pick = base_two_nxt ? base_sel_two_r : base_sel_one_r; // R16

  always @(posedge clk) begin
    if (reset) begin
      base_two_sel_r <= 1'b0;
      s_addr_r <= 16'h0000;
      device_port_r <= 8'h00;
    end else begin
      base_two_sel_r <= base_two_nxt; // R15
      s_addr_r <= {base_pick, mem_addr_low_r}; // R25 R11
      device_port_r <= base_pick; // R17
    end
  end
endmodule // msq_unit
`default_nettype wire

// ---- verilog/msq_defs.vh ----
// constants for the microsequencer and address unit
`ifndef MSQ_DEFS_VH
`define MSQ_DEFS_VH
// widths
`define MSQ_DW         16
`define MSQ_UPW        14
`define MSQ_BW         8
`define MSQ_NCW        40
`define MSQ_SHW        4
// adder operand select
`define MSQ_SRC_B      3'h0
`define MSQ_SRC_LIT    3'h1
`define MSQ_SRC_CTR    3'h2
`define MSQ_SRC_ALT    3'h3
`define MSQ_SRC_ADDR   3'h4
// adder function
`define MSQ_FN_ADD     2'h0
`define MSQ_FN_AND     2'h1
`define MSQ_FN_OR      2'h2
`define MSQ_FN_XOR     2'h3
// shifter matrix destination bits
`define MSQ_D_A        0
`define MSQ_D_B        1
`define MSQ_D_WBUF     2
`define MSQ_D_ALT      3
`define MSQ_D_MAL      4
`define MSQ_D_BS1      5
`define MSQ_D_BS2      6
`define MSQ_D_SHC      7
`define MSQ_D_CTR      8
`define MSQ_DSTW       9
// input selection gate choices
`define MSQ_IN_LIT     1'b0
`define MSQ_IN_SHF     1'b1
// nanoinstruction successor fields, bits 1 through 16 (index 0..15)
`define MSQ_N_TRUE_LO  0
`define MSQ_N_FALSE_LO 8
// successor code layout: [1:0] inc value, [2] alt source, [3] load alt from pc
`define MSQ_SUC_STEP   8'h01
// memory/device command codes
`define MSQ_CMD_NONE   2'h0
`define MSQ_CMD_RW1    2'h1
`define MSQ_CMD_RW2    2'h2
`endif

// ---- verilog/msq_shifter.v ----
// shifter matrix: left or right shift, end-off or end-around
`timescale 1ns/1ps
`default_nettype none
`include "msq_defs.vh"
module msq_shifter (
  // data
  input  wire [15:0] din,
  input  wire [3:0]  amount,
  input  wire        dir_left,
  input  wire        around,
  output reg  [15:0] dout
);
  reg [31:0] dbl;
  always @* begin
    dbl = {din, din};
    if (dir_left) begin
      if (around) dout = dbl[31 - amount -: 16]; // R2
      else dout = din << amount; // R2
    end else begin
      if (around) dout = dbl[amount +: 16]; // R2
      else dout = din >> amount; // R2
    end
  end
endmodule // msq_shifter
`default_nettype wire

// ---- verilog/msq_incrementer.v ----
// incrementer: adds 0, 1 or 2 to the chosen micro address source
`timescale 1ns/1ps
`default_nettype none
`include "msq_defs.vh"
module msq_incrementer (
  // sources
  input  wire [13:0] pc,
  input  wire [13:0] alt,
  // controls
  input  wire        use_alt,
  input  wire [1:0]  inc,
  // result
  output wire [13:0] sum
);
  wire [13:0] src = use_alt ? alt : pc; // R8
  assign sum = src + {12'h000, inc}; // R8
endmodule // msq_incrementer
`default_nettype wire

// ---- testbench/msq_mem_model.sv ----
// behavioural s-level memory that answers a read one cycle later
`timescale 1ns/1ps
`default_nettype none
module msq_mem_model (
  // clock
  input  wire logic        clk,
  // request
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  // answer
  output var  logic [15:0] rdata,
  output var  logic        rvalid
);
  logic [15:0] mem [0:255];
  initial {rdata, rvalid} = 17'h00000;
  // ==========
  // access; the data lines change once the answer is over
  always @(posedge clk) begin
    rvalid <= rd;
    if (wr) mem[addr[7:0]] <= wdata;
    rdata <= rd ? mem[addr[7:0]] : ~rdata;
  end
endmodule // msq_mem_model
`default_nettype wire

// ---- testbench/msq_unit_chk.sv ----
// concurrent checks on the ports of the microsequencer and address unit
`timescale 1ns/1ps
`default_nettype none
module msq_unit_chk (
  input wire logic        clk, reset, phase1, phase3_done, phase3_ext,
  input wire logic        type2, type2_pc, op_a, test_ovf,
  input wire logic [13:0] type2_addr,
  input wire logic [39:0] nano_ctl,
  input wire logic [8:0]  shf_dest,
  input wire logic [1:0]  mem_cmd,
  input wire logic [13:0] micro_pc_r,
  input wire logic [15:0] s_addr_r,
  input wire logic [7:0]  device_port_r,
  input wire logic        base_two_sel_r, a_load_en_r, counter_overflow_flag_r,
  input wire logic [39:0] nano_ctl_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========
  // assertions
  base_one_a:
    assert property (mem_cmd == 2'h1 |=> !base_two_sel_r) else $error("base one not picked");
  base_two_a:
    assert property (mem_cmd == 2'h2 |=> base_two_sel_r) else $error("base two not picked");
  sel_hold_a:
    assert property (mem_cmd == 2'h0 |=> $stable(base_two_sel_r)) else $error("selection moved");
  port_addr_a:
    assert property (s_addr_r[15:8] == device_port_r) else $error("port differs from base");
  ovf_clear_a:
    assert property (test_ovf |=> !counter_overflow_flag_r) else $error("overflow not cleared");
  step_succ_a:
    assert property (phase1 && type2 && !type2_pc && !op_a
      |=> micro_pc_r == $past(micro_pc_r) + 14'h0001) else $error("no step successor");
  pc_load_a:
    assert property (phase1 && type2 && type2_pc && !op_a
      |=> micro_pc_r == $past(type2_addr)) else $error("micro pc not loaded");
  a_load_a:
    assert property (phase3_done && !phase3_ext && shf_dest[0] |=> a_load_en_r)
      else $error("a load missing");
  ext_block_a:
    assert property (phase3_ext |=> !a_load_en_r) else $error("load while extended");
  nano_cap_a:
    assert property (!phase1 |=> nano_ctl_r == $past(nano_ctl)) else $error("control not held");
  // ==========
  // covers
  cover property (mem_cmd == 2'h2 ##1 mem_cmd == 2'h0);
  cover property ($rose(counter_overflow_flag_r));
  cover property (phase3_ext && shf_dest != 9'h000);
endmodule // msq_unit_chk
`default_nettype wire

// ---- testbench/msq_unit_test.sv ----
// self-checking bench for the microsequencer and address unit
`timescale 1ns/1ps
`default_nettype none
module msq_unit_test;
  logic clk = 1'b0, reset = 1'b1, phase1, phase3_done, phase3_ext, type2, type2_pc, type2_alt;
  logic type2_lit, op_a, cond_true, add_to_b, shf_left, shf_around, in_sel, ctr_inc, test_ovf;
  logic b_in_load, base_two_sel_r, a_load_en_r, counter_overflow_flag_r, mem_wr, mem_rd;
  logic [13:0] type2_addr, micro_addr_r, micro_pc_r, alt_micro_pc_r;
  logic [7:0]  type2_literal, device_port_r;
  logic [15:0] nano_succ, b_in, s_addr_r, write_buffer_reg_r, adder_out_r, a_load_r;
  logic [39:0] nano_ctl, nano_ctl_r;
  logic [2:0]  add_src;
  logic [1:0]  add_fn, mem_cmd;
  logic [8:0]  shf_dest;
  int          mismatches = 0, checks_done = 0, i;
  always #12.5 clk = ~clk;
  msq_unit dut_u (.clk, .reset, .phase1, .phase3_done, .phase3_ext, .type2, .type2_pc,
    .type2_alt, .type2_lit, .type2_addr, .type2_literal, .op_a, .nano_succ, .cond_true,
    .nano_ctl, .add_src, .add_fn, .add_to_b, .shf_left, .shf_around, .shf_dest, .in_sel,
    .ctr_inc, .test_ovf, .mem_cmd, .b_in, .b_in_load, .micro_addr_r, .micro_pc_r,
    .alt_micro_pc_r, .s_addr_r, .device_port_r, .base_two_sel_r, .write_buffer_reg_r,
    .a_load_r, .a_load_en_r, .adder_out_r, .counter_overflow_flag_r, .nano_ctl_r);
  msq_mem_model mem_u (.clk, .addr(s_addr_r), .wdata(write_buffer_reg_r), .wr(mem_wr),
    .rd(mem_rd), .rdata(b_in), .rvalid(b_in_load));
  // ==========
  // tasks
  task cyc; @(posedge clk); #1; endtask
  task chk(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task literal_reg(input logic [7:0] v);
    {phase1, type2, type2_lit, type2_literal} = {3'b111, v};
    cyc;
    {phase1, type2, type2_lit} = 3'b000;
  endtask
  task dest(input logic [8:0] d);
    {shf_dest, phase3_done} = {d, 1'b1};
    cyc;
    {shf_dest, phase3_done} = 10'h000;
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========
  // sequence
  initial begin
    {phase1, phase3_done, phase3_ext, type2, type2_pc, type2_alt, type2_lit, op_a} = 8'h00;
    {cond_true, add_to_b, shf_left, shf_around, in_sel, ctr_inc, test_ovf, mem_wr} = 8'h00;
    {mem_rd, type2_addr, type2_literal, nano_succ, nano_ctl, add_src, add_fn} = 0;
    {mem_cmd, shf_dest} = 11'h000;
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    chk(micro_pc_r, 0);
    chk(s_addr_r, 0);
    {phase1, type2, type2_pc, type2_addr} = {3'b111, 14'h0100};
    cyc;
    chk(micro_pc_r, 14'h0100);
    type2_pc = 1'b0;
    cyc;
    chk(micro_pc_r, 14'h0101);
    {type2, nano_succ, cond_true} = {1'b0, 16'h0201, 1'b1};
    cyc;
    chk(micro_pc_r, 14'h0102);
    cond_true = 1'b0;
    cyc;
    chk(micro_pc_r, 14'h0104);
    op_a = 1'b1;
    cyc;
    chk(micro_pc_r, 14'h0104);
    chk(micro_addr_r, 14'h0106);
    {op_a, type2, type2_alt, type2_addr} = {3'b011, 14'h0200};
    cyc;
    chk(alt_micro_pc_r, 14'h0200);
    chk(micro_pc_r, 14'h0105);
    {type2, type2_alt, nano_succ, cond_true} = {2'b00, 16'h0605, 1'b1};
    cyc;
    chk(micro_pc_r, 14'h0201);
    cond_true = 1'b0;
    cyc;
    chk(micro_pc_r, 14'h0202);
    nano_succ = 16'h0901;
    cyc;
    chk(alt_micro_pc_r, 14'h0202);
    chk(micro_pc_r, 14'h0203);
    {phase1, nano_ctl} = {1'b0, 40'ha50f1e2d3c};
    cyc;
    chk(nano_ctl_r, 40'ha50f1e2d3c);
    $display("test sequencing done");
    add_src = 3'h1;
    literal_reg(8'h3c);
    cyc;
    dest(9'h020);
    literal_reg(8'h5a);
    dest(9'h010);
    literal_reg(8'h71);
    cyc;
    dest(9'h040);
    for (i = 1; i < 5; i++) begin
      mem_cmd = (i == 1) ? 2'h1 : (i == 2) ? 2'h2 : 2'h0;
      cyc;
      chk(s_addr_r, (i == 1) ? 16'h3c5a : 16'h715a);
      chk(device_port_r, (i == 1) ? 8'h3c : 8'h71);
      chk(base_two_sel_r, i != 1);
    end
    literal_reg(8'h99);
    phase3_ext = 1'b1;
    dest(9'h010);
    {phase3_ext, mem_cmd} = 3'h2;
    cyc;
    chk(s_addr_r, 16'h715a);
    $display("test addressing done");
    literal_reg(8'hff);
    dest(9'h100);
    add_src = 3'h2;
    cyc;
    cyc;
    chk(adder_out_r, 16'h00ff);
    ctr_inc = 1'b1;
    cyc;
    ctr_inc = 1'b0;
    chk(counter_overflow_flag_r, 1'b1);
    test_ovf = 1'b1;
    cyc;
    chk(counter_overflow_flag_r, 1'b0);
    dest(9'h100);
    ctr_inc = 1'b1;
    cyc;
    {ctr_inc, test_ovf} = 2'b00;
    chk(counter_overflow_flag_r, 1'b0);
    $display("test counter done");
    literal_reg(8'h04);
    dest(9'h100);
    cyc;
    dest(9'h080);
    add_src = 3'h1;
    literal_reg(8'h81);
    cyc;
    for (i = 0; i < 3; i++) begin
      {shf_left, shf_around} = (i == 0) ? 2'b10 : (i == 1) ? 2'b11 : 2'b01;
      dest(9'h004);
      chk(write_buffer_reg_r, (i == 0) ? 16'h1000 : (i == 1) ? 16'h1008 : 16'h0810);
    end
    dest(9'h001);
    chk(a_load_r, 16'h0810);
    chk(a_load_en_r, 1'b1);
    {in_sel, shf_dest, phase3_done} = {1'b1, 9'h018, 1'b1};
    cyc;
    {in_sel, add_to_b, shf_dest} = {2'b01, 9'h000};
    cyc;
    {add_to_b, phase3_done, add_src, add_fn} = {2'b00, 3'h0, 2'h1};
    chk(s_addr_r, 16'h7110);
    chk(alt_micro_pc_r, 14'h0810);
    cyc;
    cyc;
    chk(adder_out_r, 16'h8100);
    mem_wr = 1'b1;
    cyc;
    {mem_wr, mem_rd} = 2'b01;
    cyc;
    mem_rd = 1'b0;
    for (i = 0; i < 8 && b_in_load !== 1'b1; i++) cyc;
    if (b_in_load !== 1'b1) begin
      mismatches++;
    end else begin
      cyc;
      cyc;
      chk(adder_out_r, 16'h0810);
      $display("test memory done");
      reset = 1'b1;
      cyc;
      chk(micro_pc_r, 0);
      chk({s_addr_r, device_port_r, base_two_sel_r}, 0);
      chk(counter_overflow_flag_r, 0);
      reset = 1'b0;
      cyc;
      chk(base_two_sel_r, 1'b1);
      chk(s_addr_r, 0);
      $display("test reset done");
    end
    tally_and_finish;
  end
endmodule // msq_unit_test

bind msq_unit msq_unit_chk chk_u (.clk, .reset, .phase1, .phase3_done, .phase3_ext, .type2,
  .type2_pc, .op_a, .test_ovf, .type2_addr, .nano_ctl, .shf_dest, .mem_cmd, .micro_pc_r,
  .s_addr_r, .device_port_r, .base_two_sel_r, .a_load_en_r, .counter_overflow_flag_r,
  .nano_ctl_r);
`default_nettype wire
